// [rtl/state_pointer_invalidate_decoder.sv]
// top of the state pointer invalidate decoder with its registers
//
// Functional notes
// RULE1 - top three bits equal three: graphics pipe
// RULE2 - subtype bits 28:27 equal one, single dword
// RULE3 - opcode bits 26:24 equal zero, pipelined
// RULE4 - sub-opcode bits 23:16 equal 02h
// RULE5 - producer sends zeros in bits 15:3
// RULE6 - bit 2 invalidates pipelined pointers
// RULE7 - bit 1 invalidates constant buffer pointer
// RULE8 - bit 0 invalidates media state pointers
// RULE9 - no prefetch through an invalid pointer
// RULE10 - producer reissues pointers before dependent rendering
// RULE11 - only selected, listed pointer groups touched
// RULE12 - per-group valid flag, set then cleared
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module state_pointer_invalidate_decoder
    import spi_dec_pkg::*;
#(
    parameter int CNT_W = INV_COUNT_W
)
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // command stream from the streamer
    input wire logic CMD_VALID_I,
    input wire logic [31:0] CMD_DW_I,
    // pointer-setting commands executed elsewhere
    input wire logic PIPE_PTR_SET_I,
    input wire logic CC_PTR_SET_I,
    input wire logic CONST_BUF_SET_I,
    input wire logic MEDIA_PTR_SET_I,
    // prefetch requests through a pointer group
    input wire logic PREFETCH_REQ_I,
    input wire logic [1:0] PREFETCH_GRP_I,
    // register port
    input wire logic [spi_dec_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    // results
    output logic INV_DONE_O,
    output logic CMD_REJECT_O,
    output logic RSVD_ERR_O,
    output logic [spi_dec_pkg::NUM_GROUPS-1:0] PTR_VALID_O,
    output logic PREFETCH_GRANT_O,
    output logic PREFETCH_DENY_O
);

    import spi_dec_pkg::*;

    // decoder run state
    dec_state_t state_r;
    dec_state_t state_nxt;

    // control register fields
    logic dec_en_r;
    logic strict_r;

    // sticky error and command history
    logic rsvd_err_r;
    logic rsvd_err_nxt;
    logic [CNT_W-1:0] inv_cnt_r;
    logic [31:0] last_cmd_r;

    // one-cycle result pulses
    logic inv_done_r;
    logic reject_r;
    logic grant_r;
    logic deny_r;

    // registered read data
    logic [31:0] rdata_r;

    // outputs of the submodules
    logic is_inv;
    logic rsvd_nz;
    logic [NUM_GROUPS-1:0] sel;
    logic [NUM_GROUPS-1:0] valid;

    // field decoder of the incoming dword
    spi_cmd_field_decode u_decode (
        .dw_i(CMD_DW_I),
        .is_inv_o(is_inv),
        .rsvd_nz_o(rsvd_nz),
        .sel_o(sel)
    );

    // commands only count while the decoder runs
    wire running = state_r == ST_RUN;
    wire cmd_hit = CMD_VALID_I && running && is_inv;

    // strict mode refuses commands with reserved bits set
    wire strict_block = strict_r && rsvd_nz;
    wire cmd_exec = cmd_hit && !strict_block;
    wire cmd_rej = cmd_hit && strict_block;

    // invalidate only groups whose select bit is set
    wire [NUM_GROUPS-1:0] clr_vec = cmd_exec ? sel : '0; // RULE11

    // pointer-setting commands raise their flags again
    wire [NUM_GROUPS-1:0] set_vec;
    assign set_vec[GRP_PIPE] = PIPE_PTR_SET_I; // RULE12
    assign set_vec[GRP_CC] = CC_PTR_SET_I; // RULE12
    assign set_vec[GRP_CONST] = CONST_BUF_SET_I; // RULE12
    assign set_vec[GRP_MEDIA] = MEDIA_PTR_SET_I; // RULE12

    // valid flag bank
    spi_ptr_valid_bank #(
        .GROUPS(NUM_GROUPS)
    ) u_bank (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .set_i(set_vec),
        .clr_i(clr_vec),
        .valid_o(valid)
    );

    // one-hot form of the requested group
    wire [NUM_GROUPS-1:0] pf_onehot;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_GROUPS; gi = gi + 1)
        begin : g_pf_sel
            assign pf_onehot[gi] = PREFETCH_GRP_I == 2'(gi);
        end
    endgenerate

    // prefetch gating on the current flag of the requested group
    wire grp_valid = |(pf_onehot & valid);

    // exactly one answer per request
    wire pf_grant = PREFETCH_REQ_I && grp_valid; // RULE9
    wire pf_deny = PREFETCH_REQ_I && !grp_valid; // RULE9

    // register decode
    wire sel_ctrl = REG_ADDR_I == REG_CTRL;
    wire sel_stat = REG_ADDR_I == REG_STATUS;
    wire sel_cnt = REG_ADDR_I == REG_INV_COUNT;
    wire sel_last = REG_ADDR_I == REG_LAST_CMD;

    // write strobes per register
    wire wr_ctrl = REG_WR_I && sel_ctrl;
    wire wr_stat = REG_WR_I && sel_stat;
    wire err_clr = wr_stat && REG_WDATA_I[STAT_RSVD_ERR_BIT];

    // write data fields of the control register
    wire wdata_dec_en = REG_WDATA_I[CTRL_DEC_EN_BIT];
    wire wdata_strict = REG_WDATA_I[CTRL_STRICT_BIT];

    // sticky reserved-bit error, a new error wins over the clear
    wire err_set = cmd_hit && rsvd_nz;
    assign rsvd_err_nxt = err_set ? 1'b1 : (err_clr ? 1'b0 : rsvd_err_r);

    // read value assembly
    wire [31:0] ctrl_word = {30'h0, strict_r, dec_en_r};
    wire [31:0] stat_word = {23'h0, rsvd_err_r, 4'h0, valid};
    wire [31:0] cnt_word = {{(32-CNT_W){1'b0}}, inv_cnt_r};

    // each word gated by its select, at most one is open
    wire [31:0] ctrl_part = sel_ctrl ? ctrl_word : 32'h0;
    wire [31:0] stat_part = sel_stat ? stat_word : 32'h0;
    wire [31:0] cnt_part = sel_cnt ? cnt_word : 32'h0;
    wire [31:0] last_part = sel_last ? last_cmd_r : 32'h0;
    wire [31:0] rd_mux = ctrl_part | stat_part | cnt_part | last_part;

    // decoder run state follows the enable
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
                if (dec_en_r)
                    state_nxt = ST_RUN;
            ST_RUN:
                if (!dec_en_r)
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // decode enable bit of the control register
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            dec_en_r <= CTRL_DEC_EN_RST;
        else if (wr_ctrl)
            dec_en_r <= wdata_dec_en;
    end

    // strict reserved-bit check of the control register
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            strict_r <= CTRL_STRICT_RST;
        else if (wr_ctrl)
            strict_r <= wdata_strict;
    end

    // error flag
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            rsvd_err_r <= 1'b0;
        else
            rsvd_err_r <= rsvd_err_nxt; // RULE5
    end

    // executed command count, wraps at its width
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            inv_cnt_r <= '0;
        else if (cmd_exec)
            inv_cnt_r <= inv_cnt_r + 1'b1;
    end

    // last executed command dword
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            last_cmd_r <= 32'h0;
        else if (cmd_exec)
            last_cmd_r <= CMD_DW_I;
    end

    // done pulse after an executed invalidate
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            inv_done_r <= 1'b0;
        else
            inv_done_r <= cmd_exec;
    end

    // reject pulse after a refused invalidate
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            reject_r <= 1'b0;
        else
            reject_r <= cmd_rej;
    end

    // grant pulse when the requested pointer is valid
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            grant_r <= 1'b0;
        else
            grant_r <= pf_grant; // RULE9
    end

    // deny pulse when the requested pointer is invalid
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            deny_r <= 1'b0;
        else
            deny_r <= pf_deny; // RULE9
    end

    // read value held for one cycle, zero otherwise
    wire [31:0] rdata_nxt = REG_RD_I ? rd_mux : 32'h0;

    // read data in the cycle after the strobe only
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            rdata_r <= 32'h0;
        else
            rdata_r <= rdata_nxt;
    end

    // read port straight from its flop
    assign REG_RDATA_O = rdata_r;

    // command results straight from flops
    assign INV_DONE_O = inv_done_r;
    assign CMD_REJECT_O = reject_r;
    assign RSVD_ERR_O = rsvd_err_r;

    // flag bank and prefetch answers straight from flops
    assign PTR_VALID_O = valid; // RULE12
    assign PREFETCH_GRANT_O = grant_r;
    assign PREFETCH_DENY_O = deny_r;

endmodule // state_pointer_invalidate_decoder
`default_nettype wire

// [rtl/spi_dec_pkg.sv]
// shared constants for the state pointer invalidate decoder
package spi_dec_pkg;

    // command dword field positions
    localparam int TYPE_MSB = 31;
    localparam int TYPE_LSB = 29;
    localparam int SUBTYPE_MSB = 28;
    localparam int SUBTYPE_LSB = 27;
    localparam int OPCODE_MSB = 26;
    localparam int OPCODE_LSB = 24;
    localparam int SUBOP_MSB = 23;
    localparam int SUBOP_LSB = 16;
    localparam int RSVD_MSB = 15;
    localparam int RSVD_LSB = 3;
    localparam int SEL_PIPE_BIT = 2;
    localparam int SEL_CONST_BIT = 1;
    localparam int SEL_MEDIA_BIT = 0;

    // command field encodings
    localparam logic [2:0] GRAPHICS_PIPE_TYPE = 3'h3;
    localparam logic [1:0] SINGLE_DWORD_SUBTYPE = 2'h1;
    localparam logic [2:0] PIPELINED_OPCODE_GROUP = 3'h0;
    localparam logic [7:0] SUBOP_PTR_INVALIDATE = 8'h02;

    // pointer groups, one valid flag each
    localparam int NUM_GROUPS = 4;
    localparam int GRP_PIPE = 0;
    localparam int GRP_CC = 1;
    localparam int GRP_CONST = 2;
    localparam int GRP_MEDIA = 3;
    localparam logic [3:0] VALID_RST = 4'h0;

    // register bus
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INV_COUNT = 8'h08;
    localparam logic [7:0] REG_LAST_CMD = 8'h0C;

    // control and status fields
    localparam int CTRL_DEC_EN_BIT = 0;
    localparam int CTRL_STRICT_BIT = 1;
    localparam logic CTRL_DEC_EN_RST = 1'b1;
    localparam logic CTRL_STRICT_RST = 1'b0;
    localparam int STAT_VALID_LSB = 0;
    localparam int STAT_RSVD_ERR_BIT = 8;
    localparam int INV_COUNT_W = 16;

    // block state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01
    } dec_state_t;

endpackage

// [rtl/spi_cmd_field_decode.sv]
// splits a command dword and recognises the pointer invalidate command
`timescale 1ns/1ps
`default_nettype none
module spi_cmd_field_decode
    import spi_dec_pkg::*;
(
    input wire logic [31:0] dw_i,
    output logic is_inv_o,
    output logic rsvd_nz_o,
    output logic [NUM_GROUPS-1:0] sel_o
);

    // field comparisons of the command header
    wire type_ok = dw_i[TYPE_MSB:TYPE_LSB] == GRAPHICS_PIPE_TYPE; // RULE1
    wire sub_ok = dw_i[SUBTYPE_MSB:SUBTYPE_LSB] == SINGLE_DWORD_SUBTYPE; // RULE2
    wire op_ok = dw_i[OPCODE_MSB:OPCODE_LSB] == PIPELINED_OPCODE_GROUP; // RULE3
    wire subop_ok = dw_i[SUBOP_MSB:SUBOP_LSB] == SUBOP_PTR_INVALIDATE; // RULE4

    assign is_inv_o = type_ok && sub_ok && op_ok && subop_ok; // RULE4
    // reserved bits are flagged, the producer must send zeros
    assign rsvd_nz_o = |dw_i[RSVD_MSB:RSVD_LSB]; // RULE5

    // select bits onto the pointer groups
    assign sel_o[GRP_PIPE] = dw_i[SEL_PIPE_BIT]; // RULE6
    assign sel_o[GRP_CC] = dw_i[SEL_PIPE_BIT]; // RULE11
    assign sel_o[GRP_CONST] = dw_i[SEL_CONST_BIT]; // RULE7
    assign sel_o[GRP_MEDIA] = dw_i[SEL_MEDIA_BIT]; // RULE8

endmodule // spi_cmd_field_decode
`default_nettype wire

// [rtl/spi_ptr_valid_bank.sv]
// one valid flag per pointer group, set by pointer commands
`timescale 1ns/1ps
`default_nettype none
module spi_ptr_valid_bank
    import spi_dec_pkg::*;
#(
    parameter int GROUPS = NUM_GROUPS
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [GROUPS-1:0] set_i,
    input wire logic [GROUPS-1:0] clr_i,
    output logic [GROUPS-1:0] valid_o
);

    // a fresh pointer command wins over an invalidate in the same cycle
    genvar g;
    generate
        for (g = 0; g < GROUPS; g = g + 1)
        begin : g_flag
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    valid_o[g] <= VALID_RST[g];
                else if (set_i[g])
                    valid_o[g] <= 1'b1; // RULE12
                else if (clr_i[g])
                    valid_o[g] <= 1'b0; // RULE12
            end
        end
    endgenerate

endmodule // spi_ptr_valid_bank
`default_nettype wire

// [tb/spi_dec_props.sv]
// assertion checker for the pointer invalidate decoder
`timescale 1ns/1ps
`default_nettype none
module spi_dec_props
    import spi_dec_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic CMD_VALID_I,
    input wire logic [31:0] CMD_DW_I,
    input wire logic PIPE_PTR_SET_I,
    input wire logic CC_PTR_SET_I,
    input wire logic CONST_BUF_SET_I,
    input wire logic MEDIA_PTR_SET_I,
    input wire logic PREFETCH_REQ_I,
    input wire logic [1:0] PREFETCH_GRP_I,
    input wire logic INV_DONE_O,
    input wire logic [spi_dec_pkg::NUM_GROUPS-1:0] PTR_VALID_O,
    input wire logic PREFETCH_GRANT_O,
    input wire logic PREFETCH_DENY_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    // a foreign header field never completes an invalidate
    property p_type;
        CMD_VALID_I && CMD_DW_I[31:29] != GRAPHICS_PIPE_TYPE |=> !INV_DONE_O;
    endproperty
    a_type: assert property (p_type) else $error("type");
    property p_sub;
        CMD_VALID_I && CMD_DW_I[28:27] != SINGLE_DWORD_SUBTYPE |=> !INV_DONE_O;
    endproperty
    a_sub: assert property (p_sub) else $error("subtype");
    property p_opc;
        CMD_VALID_I && CMD_DW_I[26:24] != PIPELINED_OPCODE_GROUP |=> !INV_DONE_O;
    endproperty
    a_opc: assert property (p_opc) else $error("opcode");
    property p_subop;
        CMD_VALID_I && CMD_DW_I[23:16] != SUBOP_PTR_INVALIDATE |=> !INV_DONE_O;
    endproperty
    a_subop: assert property (p_subop) else $error("subop");
    // each flag: set wins, else cleared only by its select bit
    property p_g0;
        PTR_VALID_O[0] == ($past(PIPE_PTR_SET_I) || ($past(PTR_VALID_O[0])
            && !(INV_DONE_O && $past(CMD_DW_I[2]))));
    endproperty
    a_g0: assert property (p_g0) else $error("pipe flag");
    property p_g1;
        PTR_VALID_O[1] == ($past(CC_PTR_SET_I) || ($past(PTR_VALID_O[1])
            && !(INV_DONE_O && $past(CMD_DW_I[2]))));
    endproperty
    a_g1: assert property (p_g1) else $error("colour calc flag");
    property p_g2;
        PTR_VALID_O[2] == ($past(CONST_BUF_SET_I) || ($past(PTR_VALID_O[2])
            && !(INV_DONE_O && $past(CMD_DW_I[1]))));
    endproperty
    a_g2: assert property (p_g2) else $error("const flag");
    property p_g3;
        PTR_VALID_O[3] == ($past(MEDIA_PTR_SET_I) || ($past(PTR_VALID_O[3])
            && !(INV_DONE_O && $past(CMD_DW_I[0]))));
    endproperty
    a_g3: assert property (p_g3) else $error("media flag");
    // a request is answered next cycle from the flag it saw
    sequence s_req;
        PREFETCH_REQ_I ##1 1'b1;
    endsequence
    property p_pref;
        s_req |-> PREFETCH_GRANT_O == $past(PTR_VALID_O[PREFETCH_GRP_I])
            && PREFETCH_DENY_O == !$past(PTR_VALID_O[PREFETCH_GRP_I]);
    endproperty
    a_pref: assert property (p_pref) else $error("prefetch");
endmodule // spi_dec_props
bind state_pointer_invalidate_decoder spi_dec_props spi_dec_props_i (
    .CLK_SYS_I, .RST_I, .CMD_VALID_I, .CMD_DW_I, .PIPE_PTR_SET_I,
    .CC_PTR_SET_I, .CONST_BUF_SET_I, .MEDIA_PTR_SET_I, .PREFETCH_REQ_I,
    .PREFETCH_GRP_I,
    .INV_DONE_O, .PTR_VALID_O, .PREFETCH_GRANT_O, .PREFETCH_DENY_O);
`default_nettype wire

// [tb/spi_cmd_streamer.sv]
// command streamer model: dwords and pointer-setting pulses
`timescale 1ns/1ps
`default_nettype none
module spi_cmd_streamer (
    input wire logic clk_i,
    output logic cmd_valid_o,
    output logic [31:0] cmd_dw_o,
    output logic [3:0] set_o
);
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_dw_o = 32'h0;
        set_o = 4'h0;
    end
    // dwords back to back; released bus shows the inverse of the last
    task automatic send(input logic [31:0] q[$]);
        foreach (q[i])
        begin
            cmd_valid_o <= 1'b1;
            cmd_dw_o <= q[i];
            @(posedge clk_i);
        end
        cmd_valid_o <= 1'b0;
        cmd_dw_o <= ~q[q.size()-1];
    endtask
    // reissue pointer commands before dependent work
    task automatic arm(input logic [3:0] s);
        set_o <= s;
        @(posedge clk_i);
        set_o <= 4'h0;
    endtask
endmodule // spi_cmd_streamer
`default_nettype wire

// [tb/state_pointer_invalidate_decoder_bench.sv]
// self-checking bench for the pointer invalidate decoder
`timescale 1ns/1ps
`default_nettype none
module state_pointer_invalidate_decoder_bench;
    import spi_dec_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cv, pf_req, wr, rd, done, rej, rerr, grant, deny;
    logic [31:0] dw, wdata, rdata, last, r;
    logic [3:0] set, valid, mv;
    logic [1:0] pf_grp;
    logic [7:0] addr;
    logic [31:0] fm [4] = '{32'h4000_0000, 32'h1800_0000, 32'h0100_0000,
        32'h0001_0000};
    int errors = 0;
    int samples_checked = 0;
    int cnt = 0;
    always #12.5 clk = ~clk;
    spi_cmd_streamer sc_i (.clk_i(clk), .cmd_valid_o(cv), .cmd_dw_o(dw),
        .set_o(set));
    state_pointer_invalidate_decoder state_pointer_invalidate_decoder_i (
        .CLK_SYS_I(clk), .RST_I(rst), .CMD_VALID_I(cv), .CMD_DW_I(dw),
        .PIPE_PTR_SET_I(set[0]), .CC_PTR_SET_I(set[1]),
        .CONST_BUF_SET_I(set[2]), .MEDIA_PTR_SET_I(set[3]),
        .PREFETCH_REQ_I(pf_req), .PREFETCH_GRP_I(pf_grp), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .INV_DONE_O(done), .CMD_REJECT_O(rej),
        .RSVD_ERR_O(rerr), .PTR_VALID_O(valid), .PREFETCH_GRANT_O(grant),
        .PREFETCH_DENY_O(deny));
    task automatic test_done();
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] cmd(logic [2:0] s, logic [12:0] rs);
        return {GRAPHICS_PIPE_TYPE, SINGLE_DWORD_SUBTYPE,
            PIPELINED_OPCODE_GROUP, SUBOP_PTR_INVALIDATE, rs, s};
    endfunction
    // register strobes, one cycle each
    task automatic wreg(logic [7:0] a, logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(logic [7:0] a, logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask
    // one invalidate through the streamer, model updated when it runs
    task automatic inv(logic [2:0] s, logic [12:0] rs, bit ok);
        sc_i.send('{cmd(s, rs)});
        #1;
        if (ok)
        begin
            mv = mv & ~{s[0], s[1], s[2], s[2]};
            cnt++;
            last = cmd(s, rs);
        end
        chk("done", 32'(ok), 32'(done));
        chk("valid", 32'(mv), 32'(valid));
    endtask
    task automatic pf(logic [1:0] g);
        pf_req <= 1'b1;
        pf_grp <= g;
        @(posedge clk);
        pf_req <= 1'b0;
        #1;
        chk("grant", 32'(mv[g]), 32'(grant));
        chk("deny", 32'(!mv[g]), 32'(deny));
    endtask
    task automatic arm(logic [3:0] s);
        sc_i.arm(s);
        mv = mv | s;
    endtask
    initial
    begin
        #100000;
        errors++;
        test_done();
    end
    initial
    begin
        {pf_req, wr, rd, pf_grp, addr, wdata, mv} = '0;
        void'($urandom(32'h932A));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rreg(REG_CTRL, 32'h1);
        rreg(8'h10, 32'h0);
        wreg(REG_INV_COUNT, 32'h55);
        rreg(REG_INV_COUNT, 32'h0);
        for (int s = 0; s < 8; s++)
        begin
            arm(4'hF);
            inv(3'(s), 13'h0, 1'b1);
            for (int g = 0; g < 4; g++) pf(2'(g));
        end
        foreach (fm[k])
        begin
            arm(4'hF);
            sc_i.send('{cmd(3'h7, 13'h0) ^ fm[k]});
            #1;
            chk("done", 32'h0, 32'(done));
            chk("valid", 32'(mv), 32'(valid));
        end
        repeat (24)
        begin
            r = $urandom;
            arm(r[3:0]);
            inv(r[6:4], 13'h0, 1'b1);
            pf(r[9:8]);
        end
        inv(3'h1, 13'h1000, 1'b1);
        chk("rerr", 32'h1, 32'(rerr));
        wreg(REG_CTRL, 32'h3);
        arm(4'hF);
        inv(3'h7, 13'h1, 1'b0);
        chk("reject", 32'h1, 32'(rej));
        wreg(REG_STATUS, 32'h100);
        rreg(REG_STATUS, 32'hF);
        wreg(REG_CTRL, 32'h0);
        // run state drops one edge after the enable is cleared
        @(posedge clk);
        #1;
        inv(3'h7, 13'h0, 1'b0);
        wreg(REG_CTRL, 32'h1);
        @(posedge clk);
        #1;
        sc_i.send('{cmd(3'h4, 13'h0), cmd(3'h1, 13'h0)});
        #1;
        mv = mv & 4'h4;
        cnt += 2;
        last = cmd(3'h1, 13'h0);
        chk("valid", 32'(mv), 32'(valid));
        // pointer command and invalidate in one cycle: the set wins
        fork
            sc_i.arm(4'h8);
            sc_i.send('{cmd(3'h1, 13'h0)});
        join
        #1;
        mv = mv | 4'h8;
        cnt++;
        last = cmd(3'h1, 13'h0);
        chk("done", 32'h1, 32'(done));
        chk("valid", 32'(mv), 32'(valid));
        rreg(REG_INV_COUNT, 32'(cnt[15:0]));
        rreg(REG_LAST_CMD, last);
        test_done();
    end
endmodule // state_pointer_invalidate_decoder_bench
`default_nettype wire
